// *** pie_pkg.sv ***
// package: register map, enable field layout and reset values of the interrupt enable block
package pie_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned N_EVT  = 7;

  localparam logic [11:0] OFF_ENABLE_DIRECT = 12'h300;
  localparam logic [11:0] OFF_ENABLE_SET    = 12'h304;
  // own registers: event status (write one to clear) and interrupt mask
  localparam logic [11:0] OFF_EVENT_STATUS  = 12'h310;
  localparam logic [11:0] OFF_EVENT_MASK    = 12'h314;

  // field positions inside the 32-bit registers
  localparam int unsigned POS_HALT_DONE    = 1;
  localparam int unsigned POS_SEQ_BEGIN0   = 2;
  localparam int unsigned POS_SEQ_BEGIN1   = 3;
  localparam int unsigned POS_SEQ_FINISH0  = 4;
  localparam int unsigned POS_SEQ_FINISH1  = 5;
  localparam int unsigned POS_PERIOD_END   = 6;
  localparam int unsigned POS_REPEAT_DONE  = 7;
  localparam int unsigned POS_LSB          = POS_HALT_DONE;
  localparam int unsigned POS_MSB          = POS_REPEAT_DONE;

  localparam logic [6:0] RST_ENABLE = 7'h00;
  localparam logic [6:0] RST_STATUS = 7'h00;
  localparam logic [6:0] RST_MASK   = 7'h00;
  localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

  // event vector, bit order matches the register fields from bit 1 upward
  typedef struct packed {
    logic repeat_complete_event;
    logic period_finish_event;
    logic seq1_finish_event;
    logic seq0_finish_event;
    logic seq1_begin_event;
    logic seq0_begin_event;
    logic halt_done_event;
  } pie_event_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pie_bus_req_type;
endpackage

// *** pie_sticky_bit.sv ***
// module: one sticky status bit, set by an event and cleared by a written one
module pie_sticky_bit (
  input  wire logic i_ref_clk,
  input  wire logic i_srst,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_q
);
  // set wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_q <= 1'b0;
    end else if (i_set) begin
      o_q <= 1'b1;
    end else if (i_clr) begin
      o_q <= 1'b0;
    end
  end

  a_set_sticks : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_set |=> o_q) else $error("sticky bit lost an event");
endmodule

// *** pie_gate.sv ***
// module: per-event interrupt gate, an event passes only while its enable is set
module pie_gate (
  input  wire logic i_event,
  input  wire logic i_enable,
  output logic      o_request
);
  // enable of 0 blocks, 1 lets through
  assign o_request = i_event & i_enable;
endmodule

// *** pie_regs.sv ***
// module: interrupt enable registers with event gating, status, mask and interrupt output
module pie_regs (
  input  wire logic                i_ref_clk,
  input  wire logic                i_srst,
  input  wire logic [11:0]         i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [31:0]         o_rdata,
  input  wire pie_pkg::pie_event_type i_events,
  output pie_pkg::pie_event_type   o_requests,
  output logic      [6:0]          o_enable,
  output logic                     o_irq
);
  logic [6:0]  enable;
  logic [6:0]  next_enable;
  logic [6:0]  mask;
  logic [6:0]  status;
  logic [6:0]  req_vec;
  logic [6:0]  status_clr;
  logic [6:0]  wfield;
  logic [31:0] next_rdata;
  logic        hit_direct;
  logic        hit_set;
  logic        hit_status;
  logic        hit_mask;
  logic        hit_any;

  // address decode and the enable field of the write data
  assign hit_direct = (i_addr == pie_pkg::OFF_ENABLE_DIRECT);
  assign hit_set    = (i_addr == pie_pkg::OFF_ENABLE_SET);
  assign hit_status = (i_addr == pie_pkg::OFF_EVENT_STATUS);
  assign hit_mask   = (i_addr == pie_pkg::OFF_EVENT_MASK);
  assign hit_any    = hit_direct | hit_set | hit_status | hit_mask;
  assign wfield     = i_wdata[pie_pkg::POS_MSB:pie_pkg::POS_LSB];

  // next enable: direct write loads all bits, set write only raises ones
  always_comb begin
    next_enable = enable;
    if (i_wr && hit_direct) begin
      next_enable = wfield;
    end else if (i_wr && hit_set) begin
      next_enable = enable | wfield;
    end
  end

  // shared enable vector behind both registers
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      enable <= pie_pkg::RST_ENABLE;
    end else begin
      enable <= next_enable;
    end
  end

  // interrupt mask register
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      mask <= pie_pkg::RST_MASK;
    end else if (i_wr && hit_mask) begin
      mask <= wfield;
    end
  end

  // per-event gating by the enable bits
  genvar g;
  generate
    for (g = 0; g < pie_pkg::N_EVT; g++) begin : g_evt
      pie_gate u_gate (
        .i_event   (i_events[g]),
        .i_enable  (enable[g]),
        .o_request (req_vec[g])
      );
      assign status_clr[g] = i_wr & hit_status & wfield[g];
      pie_sticky_bit u_sticky (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_set     (req_vec[g]),
        .i_clr     (status_clr[g]),
        .o_q       (status[g])
      );
    end
  endgenerate

  assign o_requests = pie_pkg::pie_event_type'(req_vec);
  assign o_enable   = enable;

  // level interrupt while an unmasked status bit is set
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status & mask);
    end
  end

  // read mux, both enable registers return the enable state
  always_comb begin
    next_rdata = pie_pkg::READ_UNMAPPED;
    if (hit_direct || hit_set) begin
      next_rdata[pie_pkg::POS_MSB:pie_pkg::POS_LSB] = enable;
    end else if (hit_status) begin
      next_rdata[pie_pkg::POS_MSB:pie_pkg::POS_LSB] = status;
    end else if (hit_mask) begin
      next_rdata[pie_pkg::POS_MSB:pie_pkg::POS_LSB] = mask;
    end
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rdata <= pie_pkg::READ_UNMAPPED;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= pie_pkg::READ_UNMAPPED;
    end
  end

  // assertions
  sequence s_direct_write;
    i_wr && hit_direct;
  endsequence

  a_direct_loads : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_direct_write |=> enable == $past(wfield)) else $error("direct write not stored");
  a_halt_gate : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_requests.halt_done_event == (i_events.halt_done_event && enable[0]))
    else $error("halt request gating wrong");
  a_begin_gate : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !enable[1] |-> !o_requests.seq0_begin_event) else $error("begin 0 not blocked");
  a_finish_gate : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_events.seq1_finish_event && enable[4]) |-> o_requests.seq1_finish_event)
    else $error("finish 1 not passed");
  a_period_gate : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !enable[5] |-> !o_requests.period_finish_event) else $error("period not blocked");
  a_repeat_gate : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_events.repeat_complete_event && enable[6]) |-> o_requests.repeat_complete_event)
    else $error("repeat not passed");
  a_set_ors : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && hit_set) |=> enable == ($past(enable) | $past(wfield)))
    else $error("set write wrong");
  a_read_enable : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_rd && hit_set && !i_wr) |=> o_rdata[7:1] == $past(enable))
    else $error("set read wrong");
  a_hold_enable : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !(i_wr && (hit_direct || hit_set)) |=> $stable(enable)) else $error("enable drifted");
  a_irq_level : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    ##1 o_irq == |($past(status) & $past(mask))) else $error("irq level wrong");

  // the enable write and read steps
  sequence s_set_write;
    i_wr && hit_set;
  endsequence

  sequence s_enable_read;
    i_rd && (hit_direct || hit_set);
  endsequence

  // a direct write, a cycle without enable writes, then a read of either enable address
  sequence s_direct_then_read;
    s_direct_write ##1 !(i_wr && (hit_direct || hit_set)) ##1 s_enable_read;
  endsequence

  // a set write, a cycle without enable writes, then a read of either enable address
  sequence s_set_then_read;
    s_set_write ##1 !(i_wr && (hit_direct || hit_set)) ##1 s_enable_read;
  endsequence

  // an unmasked request caught while the mask register stays put
  sequence s_masked_request;
    (|(req_vec & mask)) && !(i_wr && hit_mask);
  endsequence

  // a status write that clears every unmasked set bit with no new unmasked request
  sequence s_irq_cleared;
    i_wr && hit_status && ((status & mask & ~wfield) == 7'h00) && ((req_vec & mask) == 7'h00);
  endsequence

  sequence s_mask_write;
    i_wr && hit_mask;
  endsequence

  // halt-done gate, both directions
  a_halt_block : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !enable[0] |-> !o_requests.halt_done_event) else $error("halt not blocked");
  a_halt_pass : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_events.halt_done_event && enable[0]) |-> o_requests.halt_done_event)
    else $error("halt not passed");

  // sequence begin gates, the halves not covered above
  a_begin0_pass : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_events.seq0_begin_event && enable[1]) |-> o_requests.seq0_begin_event)
    else $error("begin 0 not passed");
  a_begin1_block : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !enable[2] |-> !o_requests.seq1_begin_event) else $error("begin 1 not blocked");
  a_begin1_pass : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_events.seq1_begin_event && enable[2]) |-> o_requests.seq1_begin_event)
    else $error("begin 1 not passed");

  // sequence finish gates, the halves not covered above
  a_finish0_block : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !enable[3] |-> !o_requests.seq0_finish_event) else $error("finish 0 not blocked");
  a_finish0_pass : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_events.seq0_finish_event && enable[3]) |-> o_requests.seq0_finish_event)
    else $error("finish 0 not passed");
  a_finish1_block : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !enable[4] |-> !o_requests.seq1_finish_event) else $error("finish 1 not blocked");

  // period-finish and repeat-complete gates, the halves not covered above
  a_period_pass : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_events.period_finish_event && enable[5]) |-> o_requests.period_finish_event)
    else $error("period not passed");
  a_repeat_block : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !enable[6] |-> !o_requests.repeat_complete_event) else $error("repeat not blocked");

  // exact gating of every event by its own enable bit
  for (genvar k = 0; k < pie_pkg::N_EVT; k++) begin : g_gate_chk
    a_gate_exact : assert property (@(posedge i_ref_clk) disable iff (i_srst)
      req_vec[k] == (i_events[k] && enable[k])) else $error("event gating wrong");
  end
  a_request_subset : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (req_vec & ~enable) == 7'h00) else $error("request on a disabled bit");

  // set register: ones raise their bits, zeros and older bits stay; a direct write clears its zero bits
  a_set_raises : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_set_write |=> (enable & $past(wfield)) == $past(wfield))
    else $error("set write missed a bit");
  a_set_keeps : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_set_write |=> (enable & $past(enable)) == $past(enable))
    else $error("set write cleared a bit");
  a_set_zero : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && hit_set && (wfield == 7'h00)) |=> $stable(enable))
    else $error("zero set write changed enables");
  a_direct_clears : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_direct_write |=> (enable & ~$past(wfield)) == 7'h00)
    else $error("direct zero not cleared");

  // read side of every register, data in the one cycle after the strobe
  a_read_direct : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_rd && hit_direct) |=> o_rdata[7:1] == $past(enable))
    else $error("direct read wrong");
  a_read_spare : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_enable_read |=> (o_rdata[0] == 1'b0) && (o_rdata[31:8] == 24'h000000))
    else $error("spare enable bits set");
  a_shared_view : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_direct_then_read |=> o_rdata[7:1] == $past(wfield, 3))
    else $error("direct value not seen by read");
  a_set_seen : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_set_then_read |=> (o_rdata[7:1] & $past(wfield, 3)) == $past(wfield, 3))
    else $error("set value not seen by read");
  a_read_status : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_rd && hit_status) |=> o_rdata[7:1] == $past(status))
    else $error("status read wrong");
  a_read_mask : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_rd && hit_mask) |=> o_rdata[7:1] == $past(mask))
    else $error("mask read wrong");
  a_read_unmapped : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_rd && !hit_any) |=> o_rdata == pie_pkg::READ_UNMAPPED)
    else $error("unmapped read not zero");
  a_rdata_idle : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !i_rd |=> o_rdata == pie_pkg::READ_UNMAPPED) else $error("read data outside slot");
  a_own_spare : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_rd && (hit_status || hit_mask))
      |=> (o_rdata[0] == 1'b0) && (o_rdata[31:8] == 24'h000000))
    else $error("spare status bits set");

  // writes elsewhere leave the enable and mask registers alone
  a_unmapped_write : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && !hit_any) |=> $stable(enable) && $stable(mask))
    else $error("unmapped write took effect");

  // mask register loads on its own write and holds otherwise
  a_mask_loads : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_mask_write |=> mask == $past(wfield)) else $error("mask write not stored");
  a_mask_holds : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !(i_wr && hit_mask) |=> $stable(mask)) else $error("mask drifted");

  // per-bit status catch, clear and hold
  a_status_catches : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (req_vec != 7'h00) |=> (status & $past(req_vec)) == $past(req_vec))
    else $error("status missed a request");
  for (genvar k = 0; k < pie_pkg::N_EVT; k++) begin : g_status_chk
    a_status_clears : assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (status_clr[k] && !req_vec[k]) |=> !status[k]) else $error("status not cleared");
    a_status_holds : assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (!status_clr[k] && !req_vec[k]) |=> $stable(status[k])) else $error("status drifted");
  end

  // an unmasked request shows on the interrupt two edges later, a cleared one goes
  a_irq_rises : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_masked_request |-> ##2 o_irq) else $error("irq missed a masked-in event");
  a_irq_drops : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_irq_cleared |-> ##2 !o_irq) else $error("irq stayed after clear");
  a_irq_quiet : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    ((status & mask) == 7'h00) |=> !o_irq) else $error("irq without a cause");
  a_irq_raised : assert property (@(posedge i_ref_clk) disable iff (i_srst)
    ((status & mask) != 7'h00) |=> o_irq) else $error("irq not raised");

  // reset returns every register and output to its idle value
  a_reset_clears : assert property (@(posedge i_ref_clk)
    i_srst |=> (enable == pie_pkg::RST_ENABLE) && (mask == pie_pkg::RST_MASK)
      && (status == pie_pkg::RST_STATUS) && !o_irq
      && (o_rdata == pie_pkg::READ_UNMAPPED)) else $error("reset values wrong");
endmodule

// *** pie_regs_tb.sv ***
// testbench: register access, event gating and interrupt checks of the enable block
module pie_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   i_ref_clk  = 1'b0;
  logic                   i_srst     = 1'b1;
  logic [11:0]            i_addr     = 12'h000;
  logic [31:0]            i_wdata    = 32'h00000000;
  logic                   i_wr       = 1'b0;
  logic                   i_rd       = 1'b0;
  pie_pkg::pie_event_type i_events   = '0;
  logic [31:0]            o_rdata;
  pie_pkg::pie_event_type o_requests;
  logic [6:0]             o_enable;
  logic                   o_irq;
  int                     fail_count = 0;
  int                     tests_run  = 0;
  int                     cycles     = 0;

  // 200 MHz clock
  always #2.5 i_ref_clk = ~i_ref_clk;

  pie_regs i_pie_regs (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_events(i_events),
    .o_requests(o_requests), .o_enable(o_enable), .o_irq(o_irq)
  );

  // compare one result, count it and report a mismatch at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
    #1;
  endtask

  // one-cycle read strobe, data checked in the following cycle only
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  // counts, verdict and end of run
  task automatic complete_run;
    $display("mismatches=%0d comparisons=%0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, the sequence needs about a hundred cycles
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  // main sequence
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rd(12'h300, 32'h00000000);
    rd(12'h304, 32'h00000000);
    wr(12'h300, 32'hffffffff);
    rd(12'h300, 32'h000000fe);
    rd(12'h304, 32'h000000fe);
    wr(12'h304, 32'h00000000);
    chk({25'h0, o_enable}, 32'h0000007f);
    wr(12'h300, 32'hffffff01);
    rd(12'h300, 32'h00000000);
    // set register adds one enable at a time, back to back with reads
    for (int i = 1; i < 8; i++) begin
      wr(12'h304, 32'h1 << i);
      rd(12'h300, (32'h2 << i) - 32'h2);
    end
    // all events active, one enable at a time lets only that request through
    @(posedge i_ref_clk);
    i_events <= '1;
    for (int i = 0; i < 7; i++) begin
      wr(12'h300, 32'h2 << i);
      chk({25'h0, o_requests}, 32'h1 << i);
    end
    chk({31'h0, o_irq}, 32'h0);
    @(posedge i_ref_clk);
    i_events <= '0;
    rd(12'h310, 32'h000000fe);
    wr(12'h310, 32'h000000fe);
    rd(12'h310, 32'h00000000);
    // masked-in sequence 0 begin event raises and clears the interrupt
    wr(12'h314, 32'h00000004);
    wr(12'h300, 32'h000000fe);
    @(posedge i_ref_clk);
    i_events <= 7'h02;
    @(posedge i_ref_clk);
    i_events <= '0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk({31'h0, o_irq}, 32'h1);
    wr(12'h310, 32'h00000004);
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk({31'h0, o_irq}, 32'h0);
    // a write to an unmapped address leaves enables and mask alone
    wr(12'h3f0, 32'hffffffff);
    chk({25'h0, o_enable}, 32'h0000007f);
    rd(12'h314, 32'h00000004);
    rd(12'h3f0, 32'h00000000);
    complete_run();
  end
endmodule
